// *** rbps_pkg.sv ***
// Package for the backup power supervisor and clock/calendar block.
// Assumes one 200 MHz core clock and an AHB-Lite register bus.
package rbps_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int unsigned CORE_CLK_HZ       = 200000000;
   localparam int unsigned XTAL_HZ           = 32768;
   localparam int unsigned ALARM_PULSE_MS    = 250;
   localparam int unsigned ALARM_PULSE_TICKS = (XTAL_HZ * ALARM_PULSE_MS) / 1000;

   // ****************************************
   // Register offsets (byte addresses)
   // ****************************************
   localparam logic [7:0] ADDR_TIME0  = 8'h00;
   localparam logic [7:0] ADDR_TIME1  = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_CTRL   = 8'h0C;
   localparam logic [7:0] ADDR_ALARM0 = 8'h10;
   localparam logic [7:0] ADDR_ALARM1 = 8'h14;
   localparam logic [7:0] ADDR_DSTFWD = 8'h18;
   localparam logic [7:0] ADDR_DSTBWD = 8'h1C;
   localparam logic [7:0] ADDR_TSDOWN = 8'h20;
   localparam logic [7:0] ADDR_TSUP   = 8'h24;
   localparam logic [7:0] ADDR_SLOPE  = 8'h28;

   // ****************************************
   // Fields and reset values
   // ****************************************
   localparam int unsigned FLG_TOTAL   = 0;
   localparam int unsigned FLG_BAT2    = 1;
   localparam int unsigned FLG_BAT1    = 2;
   localparam int unsigned FLG_LOWVDD  = 3;
   localparam int unsigned FLG_ALARM   = 4;
   localparam int unsigned CTRL_TSCLR  = 12;
   localparam int unsigned SLOPE_BACKUP_TEMP_SENSE_ENABLE  = 7;
   localparam int unsigned TS_VALID    = 31;
   localparam logic [4:0]  FLAGS_RST   = 5'h01;
   localparam logic [4:0]  DATE_RST    = 5'h01;
   localparam logic [3:0]  MON_RST     = 4'h1;
   localparam logic [2:0]  BO_SEL_MAX  = 3'h5;
   localparam logic [5:0]  MAX_SEC     = 6'h3B;
   localparam logic [4:0]  MAX_HOUR    = 5'h17;
   localparam logic [3:0]  MAX_MON     = 4'hC;
   localparam logic [6:0]  MAX_YEAR    = 7'h63;
   localparam logic [2:0]  MAX_WDAY    = 3'h6;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      PM_NORMAL = 2'b01,
      PM_BACKUP = 2'b10
   } rbps_pm_e;

   // Supply comparator results, asynchronous to the core clock
   typedef struct packed {
      logic total_loss;
      logic bat_lt_75;
      logic bat_lt_85;
      logic vdd_lt_brownout;
      logic vdd_gt_trip_hys;
      logic vdd_gt_bat_hys;
      logic vdd_lt_trip;
      logic vdd_lt_bat_hys;
   } rbps_cmp_s;

   typedef struct packed {
      logic [6:0] yr;
      logic [3:0] mo;
      logic [4:0] dt;
      logic [4:0] hr;
      logic [5:0] mn;
   } rbps_ts_s;

   typedef struct packed {
      logic       dst_en;
      logic [2:0] bo_sel;
      logic       out_bk_en;
      logic       alarm_en;
      logic       alarm_pulse_select;
      logic [3:0] freq_output_select;
   } rbps_ctrl_s;

endpackage : rbps_pkg

// *** rbps_supervisor.sv ***
// Clock/calendar with backup power supervisor, timestamps and alarm pin.
// Assumes comparator results and crystal come from pins; AHB-Lite master.
`timescale 1ns/1ps
module rbps_supervisor #(
   parameter int unsigned XTAL_PER_SEC = rbps_pkg::XTAL_HZ,
   parameter int unsigned PULSE_TICKS  = rbps_pkg::ALARM_PULSE_TICKS
) (
   // Clock and reset
   input  wire logic              i_core_clk,
   input  wire logic              i_rst_b,
   // AHB-Lite slave
   input  wire logic              i_hsel,
   input  wire logic [31:0]       i_haddr,
   input  wire logic [1:0]        i_htrans,
   input  wire logic              i_hwrite,
   input  wire logic [2:0]        i_hsize,
   input  wire logic [31:0]       i_hwdata,
   input  wire logic              i_hready,
   output logic [31:0]            o_hrdata,
   output logic                   o_hreadyout,
   output logic                   o_hresp,
   // Analog side
   input  wire logic              i_xtal_clk,
   input  wire rbps_pkg::rbps_cmp_s i_cmp,
   output logic                   o_backup_mode,
   output logic                   o_serial_en,
   output logic                   o_temp_conv_en,
   output logic [2:0]             o_brownout_trip_sel,
   // Interrupt or frequency pin
   output logic                   o_interrupt_or_freq_pin_o,
   output logic                   o_interrupt_or_freq_pin_oe
);
   import rbps_pkg::*;

   // ****************************************
   // Declarations
   // ****************************************
   rbps_cmp_s  cmp_m_q, cmp_q;
   logic       xt_m_q, xt_q, xt_d1_q, xtal_tick;
   logic [14:0] presc_q;
   logic       sec_tick, chk_q;
   rbps_pm_e   pm_q;
   logic       enter_bk, leave_bk;
   logic       pend_q, pwr_q, hready_q;
   logic [7:0] paddr_q;
   logic [31:0] hrdata_q, rd_mux;
   logic       wr_en, ts_clr;
   rbps_ctrl_s ctrl_q;
   logic [7:0] slope_q;
   logic [5:0] sec_q, min_q, n_sec, n_min;
   logic [4:0] hour_q, date_q, n_hour, n_date, dim;
   logic [3:0] mon_q, n_mon;
   logic [6:0] year_q, n_year;
   logic [2:0] wday_q, n_wday;
   logic       dst_q, n_dst;
   logic [5:0] al_sec_q, al_min_q, al_en_q;
   logic [4:0] al_hour_q, al_date_q;
   logic [3:0] al_mon_q;
   logic [2:0] al_wday_q;
   logic [3:0] df_mon_q, db_mon_q;
   logic [4:0] df_date_q, db_date_q, df_hour_q, db_hour_q;
   rbps_ts_s   tsd_q, tsu_q, now_ts;
   logic       tsd_vld_q, tsu_vld_q;
   logic [4:0] flags_q, flag_set, flag_clr;
   logic       al_match, alarm_live, alarm_hit, pin_active;
   logic [13:0] pulse_q;
   logic       irq_oe_d, irq_oe_q, irq_o_q;
   logic       serial_en_q, temp_en_q, backup_q;

   // ****************************************
   // Synchronisers and crystal time base
   // ****************************************
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
      begin
         cmp_m_q <= '0;
         cmp_q   <= '0;
      end
      else
      begin
         cmp_m_q <= i_cmp;
         cmp_q   <= cmp_m_q;
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
      begin
         xt_m_q  <= 1'b0;
         xt_q    <= 1'b0;
         xt_d1_q <= 1'b0;
      end
      else
      begin
         xt_m_q  <= i_xtal_clk;
         xt_q    <= xt_m_q;
         xt_d1_q <= xt_q;
      end
   end

   assign xtal_tick = xt_q & ~xt_d1_q;
   assign sec_tick  = xtal_tick && (presc_q == 15'(XTAL_PER_SEC - 1));

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
         presc_q <= '0;
      else if (sec_tick)
         presc_q <= '0;
      else if (xtal_tick)
         presc_q <= presc_q + 15'h0001;
   end

   // ****************************************
   // Power mode
   // ****************************************
   assign enter_bk = (pm_q == PM_NORMAL) && cmp_q.vdd_lt_bat_hys && cmp_q.vdd_lt_trip;
   assign leave_bk = (pm_q == PM_BACKUP) && (cmp_q.vdd_gt_bat_hys || cmp_q.vdd_gt_trip_hys);

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
         pm_q <= PM_NORMAL;
      else
      begin
         case (pm_q)
            PM_NORMAL: if (enter_bk) pm_q <= PM_BACKUP;
            PM_BACKUP: if (leave_bk) pm_q <= PM_NORMAL;
            default:   pm_q <= PM_NORMAL;
         endcase
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
      begin
         backup_q    <= 1'b0;
         serial_en_q <= 1'b1;
         temp_en_q   <= 1'b1;
      end
      else
      begin
         backup_q    <= (pm_q == PM_BACKUP);
         serial_en_q <= (pm_q == PM_NORMAL);
         temp_en_q   <= (pm_q == PM_NORMAL) || slope_q[SLOPE_BACKUP_TEMP_SENSE_ENABLE];
      end
   end

   // ****************************************
   // AHB-Lite slave, one wait state
   // ****************************************
   // The wait state lets a write land before any following read decodes
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
      begin
         pend_q   <= 1'b0;
         pwr_q    <= 1'b0;
         paddr_q  <= '0;
         hready_q <= 1'b1;
         hrdata_q <= '0;
      end
      else
      begin
         if (i_hsel && i_htrans[1] && i_hready)
         begin
            pend_q   <= 1'b1;
            pwr_q    <= i_hwrite;
            paddr_q  <= i_haddr[7:0];
            hready_q <= 1'b0;
         end
         else
         begin
            pend_q   <= 1'b0;
            hready_q <= 1'b1;
         end
         if (pend_q && !pwr_q)
            hrdata_q <= rd_mux;
      end
   end

   // Brownout alone never blocks writes; only backup mode does
   assign wr_en  = pend_q && pwr_q && (pm_q == PM_NORMAL);
   assign ts_clr = wr_en && (paddr_q == ADDR_CTRL) && i_hwdata[CTRL_TSCLR];

   always_comb
   begin
      rd_mux = '0;
      case (paddr_q)
         ADDR_TIME0:  rd_mux = {5'h00, wday_q, 3'h0, hour_q, 2'h0, min_q, 2'h0, sec_q};
         ADDR_TIME1:  rd_mux = {9'h000, year_q, 4'h0, mon_q, 3'h0, date_q};
         ADDR_STATUS: rd_mux = {25'h0000000, backup_q, dst_q, flags_q};
         ADDR_CTRL:   rd_mux = {20'h00000, ctrl_q.dst_en, ctrl_q.bo_sel, 1'b0, ctrl_q.out_bk_en, ctrl_q.alarm_en,
                                ctrl_q.alarm_pulse_select, ctrl_q.freq_output_select};
         ADDR_ALARM0: rd_mux = {3'h0, al_date_q, 3'h0, al_hour_q, 2'h0, al_min_q, 2'h0, al_sec_q};
         ADDR_ALARM1: rd_mux = {10'h000, al_en_q, 5'h00, al_wday_q, 4'h0, al_mon_q};
         ADDR_DSTFWD: rd_mux = {11'h000, df_hour_q, 3'h0, df_date_q, 4'h0, df_mon_q};
         ADDR_DSTBWD: rd_mux = {11'h000, db_hour_q, 3'h0, db_date_q, 4'h0, db_mon_q};
         ADDR_TSDOWN: rd_mux = {tsd_vld_q, 4'h0, tsd_q};
         ADDR_TSUP:   rd_mux = {tsu_vld_q, 4'h0, tsu_q};
         ADDR_SLOPE:  rd_mux = {24'h000000, slope_q};
         default:     rd_mux = '0;
      endcase
   end

   // ****************************************
   // Control registers
   // ****************************************
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
      begin
         ctrl_q  <= '0;
         slope_q <= '0;
      end
      else if (wr_en && paddr_q == ADDR_CTRL)
      begin
         ctrl_q.freq_output_select <= i_hwdata[3:0];
         ctrl_q.alarm_pulse_select <= i_hwdata[4];
         ctrl_q.alarm_en           <= i_hwdata[5];
         ctrl_q.out_bk_en          <= i_hwdata[6];
         ctrl_q.bo_sel             <= (i_hwdata[10:8] > BO_SEL_MAX) ? BO_SEL_MAX : i_hwdata[10:8];
         ctrl_q.dst_en             <= i_hwdata[11];
      end
      else if (wr_en && paddr_q == ADDR_SLOPE)
         slope_q <= i_hwdata[7:0];
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
      begin
         al_sec_q <= '0; al_min_q <= '0; al_hour_q <= '0; al_date_q <= '0;
         al_mon_q <= '0; al_wday_q <= '0; al_en_q <= '0;
         df_mon_q <= '0; df_date_q <= '0; df_hour_q <= '0;
         db_mon_q <= '0; db_date_q <= '0; db_hour_q <= '0;
      end
      else if (wr_en)
      begin
         case (paddr_q)
            ADDR_ALARM0:
            begin
               al_sec_q  <= i_hwdata[5:0];
               al_min_q  <= i_hwdata[13:8];
               al_hour_q <= i_hwdata[20:16];
               al_date_q <= i_hwdata[28:24];
            end
            ADDR_ALARM1:
            begin
               al_mon_q  <= i_hwdata[3:0];
               al_wday_q <= i_hwdata[10:8];
               al_en_q   <= i_hwdata[21:16];
            end
            ADDR_DSTFWD:
            begin
               df_mon_q  <= i_hwdata[3:0];
               df_date_q <= i_hwdata[12:8];
               df_hour_q <= i_hwdata[20:16];
            end
            ADDR_DSTBWD:
            begin
               db_mon_q  <= i_hwdata[3:0];
               db_date_q <= i_hwdata[12:8];
               db_hour_q <= i_hwdata[20:16];
            end
            default: ;
         endcase
      end
   end

   // ****************************************
   // Calendar
   // ****************************************
   // Two-digit year: divisible by four is exact up to 2099
   always_comb
   begin
      case (mon_q)
         4'h2:                      dim = (year_q[1:0] == 2'h0) ? 5'h1D : 5'h1C;
         4'h4, 4'h6, 4'h9, 4'hB:    dim = 5'h1E;
         default:                   dim = 5'h1F;
      endcase
   end

   always_comb
   begin
      n_sec  = sec_q + 6'h01;
      n_min  = min_q;
      n_hour = hour_q;
      n_date = date_q;
      n_mon  = mon_q;
      n_year = year_q;
      n_wday = wday_q;
      n_dst  = dst_q;
      if (sec_q >= MAX_SEC)
      begin
         n_sec = '0;
         n_min = min_q + 6'h01;
         if (min_q >= MAX_SEC)
         begin
            n_min  = '0;
            n_hour = hour_q + 5'h01;
            if (hour_q >= MAX_HOUR)
            begin
               n_hour = '0;
               n_wday = (wday_q >= MAX_WDAY) ? 3'h0 : wday_q + 3'h1;
               n_date = date_q + 5'h01;
               if (date_q >= dim)
               begin
                  n_date = DATE_RST;
                  n_mon  = mon_q + 4'h1;
                  if (mon_q >= MAX_MON)
                  begin
                     n_mon  = MON_RST;
                     n_year = (year_q >= MAX_YEAR) ? 7'h00 : year_q + 7'h01;
                  end
               end
            end
         end
      end
      if (ctrl_q.dst_en && n_min == 6'h00 && n_sec == 6'h00)
      begin
         if (!dst_q && n_mon == df_mon_q && n_date == df_date_q && n_hour == df_hour_q && n_hour < MAX_HOUR)
         begin
            n_hour = n_hour + 5'h01;
            n_dst  = 1'b1;
         end
         else if (dst_q && n_mon == db_mon_q && n_date == db_date_q && n_hour == db_hour_q && n_hour != 5'h00)
         begin
            n_hour = n_hour - 5'h01;
            n_dst  = 1'b0;
         end
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
      begin
         sec_q <= '0; min_q <= '0; hour_q <= '0; wday_q <= '0;
         date_q <= DATE_RST; mon_q <= MON_RST; year_q <= '0; dst_q <= 1'b0;
      end
      else if (wr_en && paddr_q == ADDR_TIME0)
      begin
         sec_q  <= i_hwdata[5:0];
         min_q  <= i_hwdata[13:8];
         hour_q <= i_hwdata[20:16];
         wday_q <= i_hwdata[26:24];
      end
      else if (wr_en && paddr_q == ADDR_TIME1)
      begin
         date_q <= i_hwdata[4:0];
         mon_q  <= i_hwdata[11:8];
         year_q <= i_hwdata[22:16];
      end
      else if (sec_tick)
      begin
         sec_q <= n_sec; min_q <= n_min; hour_q <= n_hour; wday_q <= n_wday;
         date_q <= n_date; mon_q <= n_mon; year_q <= n_year; dst_q <= n_dst;
      end
   end

   // ****************************************
   // Switchover timestamps
   // ****************************************
   assign now_ts = '{yr: year_q, mo: mon_q, dt: date_q, hr: hour_q, mn: min_q};

   // An event in the clearing cycle is kept: capture wins over clear
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
      begin
         tsd_q     <= '0;
         tsd_vld_q <= 1'b0;
      end
      else if (enter_bk && (!tsd_vld_q || ts_clr))
      begin
         tsd_q     <= now_ts;
         tsd_vld_q <= 1'b1;
      end
      else if (ts_clr)
      begin
         tsd_q     <= '0;
         tsd_vld_q <= 1'b0;
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
      begin
         tsu_q     <= '0;
         tsu_vld_q <= 1'b0;
      end
      else if (leave_bk)
      begin
         tsu_q     <= now_ts;
         tsu_vld_q <= 1'b1;
      end
      else if (ts_clr)
      begin
         tsu_q     <= '0;
         tsu_vld_q <= 1'b0;
      end
   end

   // ****************************************
   // Status flags
   // ****************************************
   always_comb
   begin
      flag_set             = '0;
      flag_set[FLG_TOTAL]  = cmp_q.total_loss;
      flag_set[FLG_BAT2]   = cmp_q.bat_lt_75;
      flag_set[FLG_BAT1]   = cmp_q.bat_lt_85 | cmp_q.bat_lt_75;
      flag_set[FLG_LOWVDD] = cmp_q.vdd_lt_brownout;
      flag_set[FLG_ALARM]  = alarm_hit;
      flag_clr             = (wr_en && paddr_q == ADDR_STATUS) ? i_hwdata[4:0] : 5'h00;
   end

   // Write one to clear; a new event in the same cycle wins
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
         flags_q <= FLAGS_RST;
      else
         flags_q <= (flags_q & ~flag_clr) | flag_set;
   end

   // ****************************************
   // Alarm and pin
   // ****************************************
   assign pin_active = (pm_q == PM_NORMAL) || ctrl_q.out_bk_en;
   assign alarm_live = ctrl_q.alarm_en && (ctrl_q.freq_output_select == 4'h0) && pin_active;
   assign al_match   = (al_en_q != 6'h00)
                     && (!al_en_q[0] || sec_q == al_sec_q)
                     && (!al_en_q[1] || min_q == al_min_q)
                     && (!al_en_q[2] || hour_q == al_hour_q)
                     && (!al_en_q[3] || date_q == al_date_q)
                     && (!al_en_q[4] || mon_q == al_mon_q)
                     && (!al_en_q[5] || wday_q == al_wday_q);
   assign alarm_hit  = chk_q && al_match && alarm_live;

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
         chk_q <= 1'b0;
      else
         chk_q <= sec_tick;
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
         pulse_q <= '0;
      else if (alarm_hit && ctrl_q.alarm_pulse_select)
         pulse_q <= 14'(PULSE_TICKS);
      else if (xtal_tick && pulse_q != 14'h0000)
         pulse_q <= pulse_q - 14'h0001;
   end

   // Frequency mode pulls low while the chosen divider bit is low
   always_comb
   begin
      if (!pin_active)
         irq_oe_d = 1'b0;
      else if (ctrl_q.freq_output_select != 4'h0)
         irq_oe_d = ~presc_q[ctrl_q.freq_output_select - 4'h1];
      else if (ctrl_q.alarm_pulse_select)
         irq_oe_d = (pulse_q != 14'h0000);
      else
         irq_oe_d = flags_q[FLG_ALARM];
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
      begin
         irq_oe_q <= 1'b0;
         irq_o_q  <= 1'b0;
      end
      else
      begin
         irq_oe_q <= irq_oe_d;
         irq_o_q  <= 1'b0;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign o_hrdata            = hrdata_q;
   assign o_hreadyout         = hready_q;
   assign o_hresp             = 1'b0;
   assign o_backup_mode       = backup_q;
   assign o_serial_en         = serial_en_q;
   assign o_temp_conv_en      = temp_en_q;
   assign o_brownout_trip_sel = ctrl_q.bo_sel;
   assign o_interrupt_or_freq_pin_o        = irq_o_q;
   assign o_interrupt_or_freq_pin_oe       = irq_oe_q;

endmodule : rbps_supervisor

// *** rbps_supervisor_sva.sv ***
// Checker for the supervisor, seeing only its ports.
// Assumes one core clock and a bus whose hready is hreadyout.
`timescale 1ns/1ps
module rbps_supervisor_sva #(
   parameter int unsigned XTAL_PER_SEC = 8,
   parameter int unsigned PULSE_TICKS  = 4
) (
   // Clock, reset, inputs
   input wire logic                i_core_clk,
   input wire logic                i_rst_b,
   input wire logic                i_hsel,
   input wire logic [1:0]          i_htrans,
   input wire logic                i_hready,
   input wire rbps_pkg::rbps_cmp_s i_cmp,
   // Outputs
   input wire logic                o_hreadyout,
   input wire logic                o_backup_mode,
   input wire logic                o_serial_en,
   input wire logic                o_temp_conv_en,
   input wire logic [2:0]          o_brownout_trip_sel,
   input wire logic                o_interrupt_or_freq_pin_o
);
   import rbps_pkg::*;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_b);
   // ****************************************
   // Properties
   // ****************************************
   sequence s_take;
      i_hsel && i_htrans[1] && i_hready && o_hreadyout;
   endsequence
   sequence s_down;
      (i_cmp.vdd_lt_bat_hys && i_cmp.vdd_lt_trip)[*6];
   endsequence
   sequence s_up;
      (i_cmp.vdd_gt_bat_hys || i_cmp.vdd_gt_trip_hys)[*6];
   endsequence
   property p_wait;
      s_take |=> !o_hreadyout ##1 o_hreadyout;
   endproperty
   property p_down;
      s_down |-> o_backup_mode;
   endproperty
   property p_up;
      s_up |-> !o_backup_mode;
   endproperty
   // Two sync flops, mode flop, output flop: four edges pin to port
   property p_sync;
      $rose(o_backup_mode) |-> $past(i_cmp.vdd_lt_bat_hys, 4) && $past(i_cmp.vdd_lt_trip, 4);
   endproperty
   property p_serial;
      o_serial_en == !o_backup_mode;
   endproperty
   property p_temp;
      (!o_backup_mode)[*2] |-> o_temp_conv_en;
   endproperty
   property p_bosel;
      o_brownout_trip_sel <= BO_SEL_MAX;
   endproperty
   property p_od;
      !o_interrupt_or_freq_pin_o;
   endproperty
   a_wait: assert property (p_wait) else $error("bus wait state wrong");
   a_down: assert property (p_down) else $error("backup not entered");
   a_up: assert property (p_up) else $error("backup not left");
   a_sync: assert property (p_sync) else $error("mode changed too early");
   a_serial: assert property (p_serial) else $error("serial enable wrong");
   a_temp: assert property (p_temp) else $error("temp conversion off");
   a_bosel: assert property (p_bosel) else $error("trip select out of range");
   a_od: assert property (p_od) else $error("pin driven high");
endmodule : rbps_supervisor_sva

bind rbps_supervisor rbps_supervisor_sva #(
   .XTAL_PER_SEC(XTAL_PER_SEC),
   .PULSE_TICKS (PULSE_TICKS)
) u_sva (
   .i_core_clk         (i_core_clk),
   .i_rst_b            (i_rst_b),
   .i_hsel             (i_hsel),
   .i_htrans           (i_htrans),
   .i_hready           (i_hready),
   .i_cmp              (i_cmp),
   .o_hreadyout        (o_hreadyout),
   .o_backup_mode      (o_backup_mode),
   .o_serial_en        (o_serial_en),
   .o_temp_conv_en     (o_temp_conv_en),
   .o_brownout_trip_sel(o_brownout_trip_sel),
   .o_interrupt_or_freq_pin_o       (o_interrupt_or_freq_pin_o)
);

// *** rbps_host_model.sv ***
// Host bus master model reaching the supervisor registers.
// Assumes a single slave; waits on hready without a count.
`timescale 1ns/1ps
module rbps_host_model (
   // Clock and answer
   input  wire logic        i_core_clk,
   input  wire logic        i_hready,
   input  wire logic [31:0] i_hrdata,
   // Requests
   output logic             o_hsel,
   output logic [31:0]      o_haddr,
   output logic [1:0]       o_htrans,
   output logic             o_hwrite,
   output logic [31:0]      o_hwdata
);
   initial
   begin
      o_hsel   = 1'b0;
      o_haddr  = 32'h0;
      o_htrans = 2'h0;
      o_hwrite = 1'b0;
      o_hwdata = 32'h0;
   end
   // One read or write transfer; returns the read data in r
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge i_core_clk);
      o_hsel   <= 1'b1;
      o_htrans <= 2'h2;
      o_haddr  <= {24'h0, a};
      o_hwrite <= w;
      o_hwdata <= ~o_hwdata;
      do @(posedge i_core_clk); while (i_hready !== 1'b1);
      o_hsel   <= 1'b0;
      o_htrans <= 2'h0;
      o_hwdata <= d;
      do @(posedge i_core_clk); while (i_hready !== 1'b1);
      r = i_hrdata;
   endtask : xfer
endmodule : rbps_host_model

// *** test_rtc_backup_power_supervisor.sv ***
// Testbench: bus, comparators, crystal and alarm pin.
// Assumes host model drives the bus; checker is bound.
`timescale 1ns/1ps
module test_rtc_backup_power_supervisor;
   import rbps_pkg::*;
   logic        clk, rst_b, xtal, hrdy, hsel, hwr, resp, bk, ser, tmp, oo, oe;
   logic [31:0] haddr, hwd, hrd, r, v;
   logic [1:0]  htr;
   logic [2:0]  bo;
   rbps_cmp_s   cmp;
   int          i, n;
   int          error_cnt = 0;
   int          compares  = 0;
   logic [7:0]  cv[3] = '{8'h1C, 8'h2C, 8'h4C};
   logic [31:0] ev[3] = '{32'h8, 32'h4, 32'h6};
   rbps_supervisor #(.XTAL_PER_SEC(8), .PULSE_TICKS(4)) DUT (
      .i_core_clk(clk), .i_rst_b(rst_b), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htr), .i_hwrite(hwr), .i_hsize(3'h2), .i_hwdata(hwd),
      .i_hready(hrdy), .o_hrdata(hrd), .o_hreadyout(hrdy), .o_hresp(resp),
      .i_xtal_clk(xtal), .i_cmp(cmp), .o_backup_mode(bk), .o_serial_en(ser),
      .o_temp_conv_en(tmp), .o_brownout_trip_sel(bo), .o_interrupt_or_freq_pin_o(oo),
      .o_interrupt_or_freq_pin_oe(oe));
   rbps_host_model u_host (
      .i_core_clk(clk), .i_hready(hrdy), .i_hrdata(hrd), .o_hsel(hsel),
      .o_haddr(haddr), .o_htrans(htr), .o_hwrite(hwr), .o_hwdata(hwd));
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial
   begin
      xtal = 1'b0;
      forever #48.7 xtal = ~xtal;
   end
   // ****************************************
   // Tasks
   // ****************************************
   task cyc(input int k);
      repeat (k) @(posedge clk);
   endtask : cyc
   task chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e)
      begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [31:0] d);
      u_host.xfer(1'b1, a, d, r);
   endtask : wr
   task rc(input logic [7:0] a, input logic [31:0] e);
      u_host.xfer(1'b0, a, 32'h0, r);
      chk(r, e);
   endtask : rc
   task setc(input logic [7:0] c);
      @(posedge clk);
      cmp <= c;
   endtask : setc
   task end_of_test;
      if (error_cnt == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_of_test
   // ****************************************
   // Sequence
   // ****************************************
   initial
   begin
      cyc(40000);
      error_cnt++;
      end_of_test;
   end
   initial
   begin
      rst_b = 1'b0;
      cmp   = 8'h0C;
      v     = $urandom(32'h09222d7a);
      cyc(5);
      rst_b <= 1'b1;
      rc(ADDR_STATUS, 32'h1);
      chk({31'h0, resp}, 32'h0);
      rc(ADDR_TIME1, 32'h101);
      rc(8'h3C, 32'h0);
      setc(8'h03);
      cyc(6);
      chk({29'h0, bk, ser, tmp}, 32'h4);
      wr(ADDR_CTRL, 32'h500);
      setc(8'h0C);
      cyc(6);
      chk({29'h0, bk, ser, tmp}, 32'h3);
      rc(ADDR_CTRL, 32'h0);
      rc(ADDR_TSDOWN, 32'h80010800);
      wr(ADDR_SLOPE, 32'h80);
      wr(ADDR_TIME0, 32'h500);
      setc(8'h03);
      cyc(6);
      chk({31'h0, tmp}, 32'h1);
      setc(8'h0C);
      cyc(6);
      rc(ADDR_TSDOWN, 32'h80010800);
      rc(ADDR_TSUP, 32'h80010805);
      wr(ADDR_CTRL, 32'h1000);
      rc(ADDR_TSDOWN, 32'h0);
      rc(ADDR_TSUP, 32'h0);
      for (i = 0; i < 8; i++)
      begin
         wr(ADDR_CTRL, 32'(i) << 8);
         v = (i > 5) ? 32'h5 : 32'(i);
         chk({29'h0, bo}, v);
      end
      for (i = 0; i < 3; i++)
      begin
         setc(cv[i]);
         cyc(4);
         wr(ADDR_STATUS, 32'h1F);
         rc(ADDR_STATUS, ev[i]);
         setc(8'h0C);
         cyc(4);
         wr(ADDR_STATUS, 32'h1F);
         rc(ADDR_STATUS, 32'h0);
      end
      repeat (4)
      begin
         v = $urandom & 32'hFF;
         wr(ADDR_SLOPE, v);
         rc(ADDR_SLOPE, v);
      end
      // Year 4 is leap, year 5 is not
      for (i = 4; i < 6; i++)
      begin
         wr(ADDR_TIME1, (32'(i) << 16) | 32'h21C);
         wr(ADDR_TIME0, 32'h00173B3B);
         cyc(240);
         rc(ADDR_TIME1, (32'(i) << 16) | ((i == 4) ? 32'h21D : 32'h301));
      end
      // Forward point at 01:00 on the first of January
      wr(ADDR_DSTFWD, 32'h00010101);
      wr(ADDR_TIME1, 32'h101);
      wr(ADDR_CTRL, 32'h800);
      wr(ADDR_TIME0, 32'h00003B3B);
      cyc(240);
      rc(ADDR_STATUS, 32'h20);
      wr(ADDR_ALARM0, 32'h3);
      wr(ADDR_ALARM1, 32'h10000);
      wr(ADDR_CTRL, 32'h20);
      n = 0;
      while (oe !== 1'b1 && n < 1000)
      begin
         cyc(1);
         n++;
      end
      chk({31'h0, oe}, 32'h1);
      rc(ADDR_STATUS, 32'h30);
      wr(ADDR_STATUS, 32'h10);
      cyc(2);
      chk({31'h0, oe}, 32'h0);
      wr(ADDR_CTRL, 32'h30);
      wr(ADDR_TIME0, 32'h0);
      n = 0;
      while (oe !== 1'b1 && n < 1000)
      begin
         cyc(1);
         n++;
      end
      n = 0;
      while (oe === 1'b1 && n < 1000)
      begin
         cyc(1);
         n++;
      end
      // Four ticks of about 19.5 cycles, the first one partial
      chk({31'h0, n >= 57 && n <= 82}, 32'h1);
      wr(ADDR_CTRL, 32'h21);
      n = 0;
      repeat (100)
      begin
         v[0] = oe;
         cyc(1);
         n += (v[0] !== oe);
      end
      chk({31'h0, n > 2}, 32'h1);
      end_of_test;
   end
endmodule : test_rtc_backup_power_supervisor
